// >>> shared/sbx_map.vh
// Purpose: Register map, fields, reset values and counts of the standby exit block
// Assumes: AXI4-Lite, 32-bit data, byte offsets below
// Notes:   Definitions only
`ifndef SBX_MAP_VH
`define SBX_MAP_VH

// ==========================================================================
// Register offsets
`define SBX_OFS_STBY      8'h00
`define SBX_OFS_SCK       8'h04
`define SBX_OFS_INT       8'h08
`define SBX_OFS_PORTA     8'h0c
`define SBX_OFS_MSTPA     8'h10
`define SBX_OFS_MSTPB     8'h14
`define SBX_OFS_MSTPC     8'h18
`define SBX_OFS_ICLR      8'h1c
`define SBX_OFS_STAT      8'h20

// ==========================================================================
// Fields
`define SBX_STBY_SEL_BIT  7
`define SBX_STBY_HOLD_BIT 6
`define SBX_WAIT_HI       4
`define SBX_WAIT_LO       0
`define SBX_SCK_HALT_BIT  0
`define SBX_SCK_SRC_BIT   1
`define SBX_PDIV_HI       10
`define SBX_PDIV_LO       8
`define SBX_BDIV_HI       18
`define SBX_BDIV_LO       16
`define SBX_NMI_EDGE_BIT  0
`define SBX_IRQEN_HI      30
`define SBX_IRQEN_LO      16
`define SBX_PA_DR_HI      7
`define SBX_PA_DR_LO      0
`define SBX_PA_DDR_HI     15
`define SBX_PA_DDR_LO     8
`define SBX_PA_BCLK       7
`define SBX_DMA_BIT       13

// ==========================================================================
// Reset values
`define SBX_STBY_RST      8'h0f
`define SBX_MSTPA_RST     16'hdfff
`define SBX_MSTPB_RST     16'hffff
`define SBX_MSTPC_RST     16'hff00

// ==========================================================================
// States and responses
`define SBX_ST_RUN        2'h0
`define SBX_ST_STBY       2'h1
`define SBX_ST_SETTLE     2'h2
`define SBX_ST_INIT       2'h3
`define SBX_RESP_OKAY     2'h0
`define SBX_RESP_SLVERR   2'h2

// ==========================================================================
// Settle counts in peripheral clock cycles
`define SBX_CNT_05        20'h00040
`define SBX_CNT_06        20'h00200
`define SBX_CNT_07        20'h00400
`define SBX_CNT_08        20'h00800
`define SBX_CNT_09        20'h01000
`define SBX_CNT_0A        20'h04000
`define SBX_CNT_0B        20'h08000
`define SBX_CNT_0C        20'h10000
`define SBX_CNT_0D        20'h20000
`define SBX_CNT_0E        20'h40000
`define SBX_CNT_0F        20'h80000
`define SBX_CNT_RSVD      20'h80000

`endif

// >>> hw/sbx_settle_timer.v
// Purpose: Oscillation settle wait counter
// Assumes: tick is a one-cycle peripheral clock enable
// Notes:   SETTLE_SHIFT shortens every count for simulation
`timescale 1ns/100ps
`include "sbx_map.vh"

module sbx_settle_timer #(
  parameter SETTLE_SHIFT = 0
) (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       load,
  input  wire [4:0] code,
  input  wire       tick,
  output reg        busy,
  output reg        done
);

  reg  [19:0] cnt;
  reg  [19:0] full;
  wire [19:0] scaled;

  // ==========================================================================
  // Code to count
  always @*
  begin
    case (code)
      5'h05:   full = `SBX_CNT_05;
      5'h06:   full = `SBX_CNT_06;
      5'h07:   full = `SBX_CNT_07;
      5'h08:   full = `SBX_CNT_08;
      5'h09:   full = `SBX_CNT_09;
      5'h0a:   full = `SBX_CNT_0A;
      5'h0b:   full = `SBX_CNT_0B;
      5'h0c:   full = `SBX_CNT_0C;
      5'h0d:   full = `SBX_CNT_0D;
      5'h0e:   full = `SBX_CNT_0E;
      5'h0f:   full = `SBX_CNT_0F;
      default: full = `SBX_CNT_RSVD; // Reserved codes take the longest wait
    endcase
  end

  assign scaled = full >> SETTLE_SHIFT;

  // ==========================================================================
  // Count down on peripheral ticks
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt  <= 20'h00000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        cnt  <= (scaled == 20'h00000) ? 20'h00001 : scaled;
        busy <= 1'b1;
      end
      else if (busy && tick)
      begin
        cnt <= cnt - 20'h00001;
        if (cnt == 20'h00001)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // sbx_settle_timer

// >>> hw/sbx_top.v
// Purpose: Deep standby exit, settle wait and bus clock pin control
// Assumes: aclk 100 MHz, synchronous active-low reset, pins synchronous to aclk
// Notes:   Registers over AXI4-Lite; module halt registers included
`timescale 1ns/100ps
`include "sbx_map.vh"

// Function
// - Init pin low in standby restarts oscillator and clocks the whole chip at once
// - Rising init pin starts CPU reset exception handling
// - Wait codes 00101 to 01000 give 64, 512, 1024, 2048 cycles; codes outside 00101 to 01111 reserved
// - Codes 01001 to 01111 give 4096 up to 524288 cycles
// - Settle wait counts peripheral clock cycles from the peripheral divider
// - Halt 0, source 0, direction out: bus clock drives the pin
// - Halt 1 stops bus clock at end of bus cycle, pin held high
// - Direction 0 makes the pin a high-impedance input in every state
// - Clock keeps running in sleep states; deep standby holds pin high when direction is out
// - Halted modules do no interrupt operations; their pending requests stay
// - Port outputs keep their levels through deep standby, except bit seven when it drives the bus clock
// - NMI edge select: 0 falling, 1 rising; standby exits on that edge
// - Sleep with deep standby select stops CPU, peripherals and oscillator
// - Enabled interrupt in standby restarts oscillator, waits, then starts handling
module sbx_top #(
  parameter SETTLE_SHIFT = 0
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        external_init_pin_n,
  input  wire        nmi_pin,
  input  wire [14:0] irq_pin_n,
  input  wire        sleep_exec,
  input  wire        dma_active,
  output reg         osc_enable,
  output reg         clock_supply,
  output reg         cpu_reset_start,
  output reg         int_exc_start,
  output reg  [7:0]  port_a_out,
  output reg  [7:0]  port_a_oe,
  output reg  [15:0] module_halt_ctrl_a,
  output reg  [15:0] module_halt_ctrl_b,
  output reg  [15:0] module_halt_ctrl_c,
  output reg  [15:0] module_int_clear
);

  reg  [7:0]  standby_control_reg;
  reg  [31:0] system_clock_ctrl_reg;
  reg  [31:0] irq_ctrl_reg;
  reg  [15:0] port_a_reg;
  reg  [1:0]  state;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         aw_full;
  reg         w_full;
  reg  [6:0]  pcnt;
  reg  [6:0]  bcnt;
  reg         pclk_tick;
  reg         bclk_tick;
  reg         bclk_level;
  reg         halt_eff;
  reg         nmi_prev;
  reg         settle_load;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  reg         wr_hit;
  wire        settle_busy;
  wire        settle_done;
  wire [6:0]  pmask;
  wire [6:0]  bmask;
  wire        nmi_edge;
  wire        wake;
  wire        do_write;
  wire        in_standby;
  wire [31:0] wmask;

  // ==========================================================================
  // Peripheral and bus clock dividers
  assign pmask = 7'h7f >> (3'h7 - system_clock_ctrl_reg[`SBX_PDIV_HI:`SBX_PDIV_LO]);
  assign bmask = 7'h7f >> (3'h7 - system_clock_ctrl_reg[`SBX_BDIV_HI:`SBX_BDIV_LO]);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pcnt       <= 7'h00;
      bcnt       <= 7'h00;
      pclk_tick  <= 1'b0;
      bclk_tick  <= 1'b0;
      bclk_level <= 1'b1;
      halt_eff   <= 1'b0;
    end
    else
    begin
      pcnt      <= pcnt + 7'h01;
      bcnt      <= bcnt + 7'h01;
      pclk_tick <= ((pcnt & pmask) == pmask);
      bclk_tick <= ((bcnt & bmask) == bmask);
      if (bclk_tick)
        bclk_level <= ~bclk_level;
      // Halt changes only where a bus clock period ends
      if (bclk_tick && bclk_level)
        halt_eff <= system_clock_ctrl_reg[`SBX_SCK_HALT_BIT];
    end
  end

  // ==========================================================================
  // Wake sources
  assign nmi_edge = irq_ctrl_reg[`SBX_NMI_EDGE_BIT] ? (nmi_pin && !nmi_prev)
                                                    : (!nmi_pin && nmi_prev);
  assign wake     = nmi_edge || (|(~irq_pin_n & irq_ctrl_reg[`SBX_IRQEN_HI:`SBX_IRQEN_LO]));
  assign in_standby = (state == `SBX_ST_STBY) || (state == `SBX_ST_SETTLE);

  // ==========================================================================
  // Standby sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state           <= `SBX_ST_RUN;
      osc_enable      <= 1'b1;
      clock_supply    <= 1'b1;
      cpu_reset_start <= 1'b0;
      int_exc_start   <= 1'b0;
      settle_load     <= 1'b0;
      nmi_prev        <= 1'b0;
    end
    else
    begin
      nmi_prev        <= nmi_pin;
      cpu_reset_start <= 1'b0;
      int_exc_start   <= 1'b0;
      settle_load     <= 1'b0;
      if (!external_init_pin_n)
      begin
        state        <= `SBX_ST_INIT;
        osc_enable   <= 1'b1;
        clock_supply <= 1'b1;
      end
      else
      begin
        case (state)
          `SBX_ST_INIT:
          begin
            state           <= `SBX_ST_RUN;
            cpu_reset_start <= 1'b1;
          end
          `SBX_ST_RUN:
          begin
            if (sleep_exec && standby_control_reg[`SBX_STBY_SEL_BIT])
            begin
              state        <= `SBX_ST_STBY;
              osc_enable   <= 1'b0;
              clock_supply <= 1'b0;
            end
          end
          `SBX_ST_STBY:
          begin
            if (wake)
            begin
              state       <= `SBX_ST_SETTLE;
              osc_enable  <= 1'b1;
              settle_load <= 1'b1;
            end
          end
          `SBX_ST_SETTLE:
          begin
            if (settle_done)
            begin
              state         <= `SBX_ST_RUN;
              clock_supply  <= 1'b1;
              int_exc_start <= 1'b1;
            end
          end
          default:
            state <= `SBX_ST_RUN;
        endcase
      end
    end
  end

  sbx_settle_timer #(
    .SETTLE_SHIFT (SETTLE_SHIFT)
  ) u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (settle_load),
    .code    (standby_control_reg[`SBX_WAIT_HI:`SBX_WAIT_LO]),
    .tick    (pclk_tick),
    .busy    (settle_busy),
    .done    (settle_done)
  );

  // ==========================================================================
  // Port A pins, bit seven carries the bus clock
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_a_out <= 8'h00;
      port_a_oe  <= 8'h00;
    end
    else
    begin
      // Bits 6 to 0 and all directions only follow register values, so they hold through standby
      port_a_out[6:0] <= port_a_reg[6:0];
      port_a_oe       <= port_a_reg[`SBX_PA_DDR_HI:`SBX_PA_DDR_LO];
      if (!port_a_reg[`SBX_PA_DDR_LO + `SBX_PA_BCLK])
        port_a_out[7] <= port_a_reg[`SBX_PA_BCLK];
      else if (halt_eff || in_standby)
        port_a_out[7] <= 1'b1;
      else if (!system_clock_ctrl_reg[`SBX_SCK_SRC_BIT])
        port_a_out[7] <= bclk_level;
      else
        port_a_out[7] <= 1'b1;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always @*
  begin
    case ({aw_addr[7:2], 2'b00})
      `SBX_OFS_STBY, `SBX_OFS_SCK, `SBX_OFS_INT, `SBX_OFS_PORTA,
      `SBX_OFS_MSTPA, `SBX_OFS_MSTPB, `SBX_OFS_MSTPC, `SBX_OFS_ICLR:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready         <= 1'b1;
      s_axi_wready          <= 1'b1;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= `SBX_RESP_OKAY;
      aw_full               <= 1'b0;
      w_full                <= 1'b0;
      aw_addr               <= 8'h00;
      w_data                <= 32'h00000000;
      w_strb                <= 4'h0;
      standby_control_reg   <= `SBX_STBY_RST;
      system_clock_ctrl_reg <= 32'h00000000;
      irq_ctrl_reg          <= 32'h00000000;
      port_a_reg            <= 16'h0000;
      module_halt_ctrl_a    <= `SBX_MSTPA_RST;
      module_halt_ctrl_b    <= `SBX_MSTPB_RST;
      module_halt_ctrl_c    <= `SBX_MSTPC_RST;
      module_int_clear      <= 16'h0000;
    end
    else
    begin
      module_int_clear <= 16'h0000;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SBX_RESP_OKAY : `SBX_RESP_SLVERR;
        case ({aw_addr[7:2], 2'b00})
          `SBX_OFS_STBY:
            standby_control_reg <= (standby_control_reg & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0]);
          `SBX_OFS_SCK:
            system_clock_ctrl_reg <= (system_clock_ctrl_reg & ~wmask) | (w_data & wmask);
          `SBX_OFS_INT:
            irq_ctrl_reg <= (irq_ctrl_reg & ~wmask) | (w_data & wmask);
          `SBX_OFS_PORTA:
            port_a_reg <= (port_a_reg & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
          `SBX_OFS_MSTPA:
          begin
            module_halt_ctrl_a <= (module_halt_ctrl_a & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
            // A busy DMA controller refuses to be halted
            if (dma_active && w_strb[1] && w_data[`SBX_DMA_BIT] && !module_halt_ctrl_a[`SBX_DMA_BIT])
              module_halt_ctrl_a[`SBX_DMA_BIT] <= 1'b0;
          end
          `SBX_OFS_MSTPB:
            module_halt_ctrl_b <= (module_halt_ctrl_b & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
          `SBX_OFS_MSTPC:
            module_halt_ctrl_c <= (module_halt_ctrl_c & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
          `SBX_OFS_ICLR:
            module_int_clear <= w_data[15:0] & wmask[15:0] & ~module_halt_ctrl_a;
          default:
            s_axi_bresp <= `SBX_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  always @*
  begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `SBX_OFS_STBY:  rd_mux = {24'h000000, standby_control_reg};
      `SBX_OFS_SCK:   rd_mux = system_clock_ctrl_reg;
      `SBX_OFS_INT:   rd_mux = irq_ctrl_reg;
      `SBX_OFS_PORTA: rd_mux = {16'h0000, port_a_reg};
      `SBX_OFS_MSTPA: rd_mux = {16'h0000, module_halt_ctrl_a};
      `SBX_OFS_MSTPB: rd_mux = {16'h0000, module_halt_ctrl_b};
      `SBX_OFS_MSTPC: rd_mux = {16'h0000, module_halt_ctrl_c};
      `SBX_OFS_ICLR:  rd_mux = 32'h00000000;
      `SBX_OFS_STAT:  rd_mux = {26'h0000000, port_a_out[7], bclk_level, halt_eff, settle_busy, state};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SBX_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? `SBX_RESP_OKAY : `SBX_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // sbx_top

// >>> tb/sbx_top_asserts.sv
// Purpose: Port checks for the standby exit block
// Assumes: One aclk domain, aresetn synchronous active low
// Notes:   Bound into sbx_top
`timescale 1ns/100ps

module sbx_top_asserts #(
  parameter SETTLE_SHIFT = 0
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        external_init_pin_n,
  input wire        nmi_pin,
  input wire [14:0] irq_pin_n,
  input wire        sleep_exec,
  input wire        dma_active,
  input wire        osc_enable,
  input wire        clock_supply,
  input wire        cpu_reset_start,
  input wire        int_exc_start,
  input wire [7:0]  port_a_out,
  input wire [7:0]  port_a_oe,
  input wire [15:0] module_halt_ctrl_a,
  input wire [15:0] module_int_clear
);
  reg [2:0] nmi_h;
  reg [1:0] irq_h;

  // Pin history for the wake cause
  always @(posedge aclk)
  begin
    nmi_h <= {nmi_h[1:0], nmi_pin};
    irq_h <= {irq_h[0], irq_pin_n != 15'h7fff};
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Sequences and properties
  sequence s_init_release;
    !external_init_pin_n ##1 external_init_pin_n;
  endsequence
  sequence s_asleep;
    !osc_enable ##1 !osc_enable;
  endsequence

  property p_init_clocks;
    !external_init_pin_n |=> osc_enable && clock_supply;
  endproperty
  a_init_clocks: assert property (p_init_clocks)
    else $error("clocks missing after init pin low");
  property p_reset_start;
    s_init_release |=> cpu_reset_start ##1 !cpu_reset_start;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("no single reset start pulse after init release");
  property p_sleep_stop;
    $fell(osc_enable) |-> !clock_supply && $past(sleep_exec);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("oscillator stopped without sleep or clocks kept");
  property p_wake_cause;
    $rose(osc_enable) && !clock_supply |-> (nmi_h[0] != nmi_h[1]) || (nmi_h[1] != nmi_h[2]) || (|irq_h);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("standby left without a wake event");
  property p_exc_after_settle;
    int_exc_start |-> clock_supply && $past(osc_enable) && !$past(clock_supply);
  endproperty
  a_exc_after_settle: assert property (p_exc_after_settle)
    else $error("interrupt start outside settle end");
  property p_clock_release;
    $rose(clock_supply) |-> int_exc_start || !$past(external_init_pin_n);
  endproperty
  a_clock_release: assert property (p_clock_release)
    else $error("clocks supplied before settle end");
  property p_pin_high;
    s_asleep ##0 port_a_oe[7] |-> port_a_out[7];
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("bus clock pin not high in standby");
  property p_ports_kept;
    s_asleep |-> $stable(port_a_out[6:0]) && $stable(port_a_oe);
  endproperty
  a_ports_kept: assert property (p_ports_kept)
    else $error("port levels changed in standby");
  property p_dma_refuse;
    $rose(module_halt_ctrl_a[13]) |-> !$past(dma_active);
  endproperty
  a_dma_refuse: assert property (p_dma_refuse)
    else $error("dma halt set while dma active");
  property p_clear_gated;
    |module_int_clear |-> (module_int_clear & module_halt_ctrl_a) == 16'h0000;
  endproperty
  a_clear_gated: assert property (p_clear_gated)
    else $error("interrupt clear reached a halted module");
endmodule // sbx_top_asserts

bind sbx_top sbx_top_asserts #(.SETTLE_SHIFT(SETTLE_SHIFT)) i_chk (
  .aclk, .aresetn, .external_init_pin_n, .nmi_pin, .irq_pin_n, .sleep_exec, .dma_active, .osc_enable,
  .clock_supply, .cpu_reset_start, .int_exc_start, .port_a_out, .port_a_oe, .module_halt_ctrl_a, .module_int_clear
);

// >>> tb/sbx_board_model.sv
// Purpose: Board oscillator and init pin driver
// Assumes: Pin changes just after aclk rising edges
// Notes:   hold sets how long the pin stays low once oscillation runs
`timescale 1ns/100ps

module sbx_board_model (
  input  wire        aclk,
  input  wire        go,
  input  wire        osc_enable,
  input  wire [15:0] hold,
  output reg         external_init_pin_n
);
  reg        busy = 1'b0;
  reg [15:0] cnt = 16'h0000;

  initial external_init_pin_n = 1'b1;

  always @(posedge aclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      cnt <= 16'h0000;
      external_init_pin_n <= 1'b0;
    end
    else if (busy && osc_enable)
    begin
      cnt <= cnt + 16'h0001;
      if (cnt == hold)
      begin
        busy <= 1'b0;
        external_init_pin_n <= 1'b1;
      end
    end
  end
endmodule // sbx_board_model

// >>> tb/sbx_top_bench.sv
// Purpose: Self-checking bench for the standby exit block
// Assumes: SETTLE_SHIFT of 6 shortens every settle wait
// Notes:   Reads, responses and settle lengths checked from queued notes
`timescale 1ns/100ps
`include "sbx_map.vh"

module sbx_top_bench;
  localparam SH = 6;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  reg         nmi_pin = 1'b0, sleep_exec = 1'b0, dma_active = 1'b0, go = 1'b0;
  reg  [14:0] irq_pin_n = 15'h7fff;
  reg  [15:0] hold = 16'h0008;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        external_init_pin_n, osc_enable, clock_supply, cpu_reset_start, int_exc_start;
  wire [7:0]  port_a_out, port_a_oe;
  wire [15:0] module_halt_ctrl_a, module_halt_ctrl_b, module_halt_ctrl_c, module_int_clear;
  integer     num_errors = 0, check_count = 0, cyc = 0, settle_cnt = 0, rst_pulses = 0, i, ex;
  reg  [31:0] seed = 32'd12;
  reg  [15:0] clr_seen = 16'h0;
  reg  [7:0]  pdata;
  reg  [1:0]  seen;
  reg  [33:0] rd_q[$];
  reg  [1:0]  b_q[$];
  integer     st_q[$];
  integer     tbl[0:15] = '{524288, 524288, 524288, 524288, 524288, 64, 512, 1024, 2048, 4096,
                            16384, 32768, 65536, 131072, 262144, 524288};

  sbx_top #(.SETTLE_SHIFT(SH)) i_dut (.*);
  sbx_board_model i_board (.aclk, .go, .osc_enable, .hold, .external_init_pin_n);

  always #5 aclk = ~aclk;

  // ==========================================================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task chk(input [33:0] got, input [33:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task close_out;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Only this bench, standing for the CPU, writes registers
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    reg aw_ok, w_ok;
    begin
      b_q.push_back(e);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        aw_ok = aw_ok | s_axi_awready;
        w_ok = w_ok | s_axi_wready;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    end
  endtask

  task rd(input [7:0] a, input [33:0] e);
    begin
      rd_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    end
  endtask

  task look(input integer n, output [1:0] s);
    begin
      s = 2'b00;
      repeat (n)
      begin
        @(posedge aclk);
        s = s | {port_a_out[7] === 1'b1, port_a_out[7] === 1'b0};
      end
    end
  endtask

  task doze;
    begin
      sleep_exec <= 1'b1;
      @(posedge aclk);
      sleep_exec <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask

  // One standby round trip; a wrong nmi edge comes first and must be ignored
  task nap(input [4:0] code, input eg, input irq);
    integer k;
    begin
      seed = xs(seed);
      k = seed % 15;
      wr(`SBX_OFS_INT, {1'b0, irq ? 15'h1 << k : 15'h0, 15'h0, eg}, 2'b00);
      wr(`SBX_OFS_SCK, {21'h0, 2'b00, code == 5'h0b, 8'h00}, 2'b00);
      nmi_pin <= eg;
      wr(`SBX_OFS_STBY, {24'h0, 1'b1, seed[0], 1'b0, code}, 2'b00);
      ex = (code > 5'h0f ? 524288 : tbl[code[3:0]]) >> SH;
      st_q.push_back(code == 5'h0b ? ex * 2 : ex);
      doze;
      chk({osc_enable, clock_supply}, 2'b00);
      nmi_pin <= !eg;
      repeat (4) @(posedge aclk);
      chk(osc_enable, 1'b0);
      if (irq)
        irq_pin_n[k] <= 1'b0;
      else
        nmi_pin <= eg;
      do @(posedge aclk); while (int_exc_start !== 1'b1);
      irq_pin_n <= 15'h7fff;
      chk(port_a_out[6:0], pdata[6:0]);
    end
  endtask

  // ==========================================================================
  // Result watcher and timeout
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (osc_enable && !clock_supply) settle_cnt = settle_cnt + 1;
    clr_seen = clr_seen | module_int_clear;
    if (cpu_reset_start === 1'b1) rst_pulses = rst_pulses + 1;
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, b_q.pop_front());
    if (int_exc_start === 1'b1)
    begin
      ex = st_q.pop_front();
      chk(settle_cnt >= ex && settle_cnt <= ex + 4, 1'b1);
      settle_cnt = 0;
    end
    if (cyc == 90000)
    begin
      num_errors = num_errors + 1;
      close_out;
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({module_halt_ctrl_a, module_halt_ctrl_b, module_halt_ctrl_c}, 48'hdfffffffff00);
    rd(`SBX_OFS_STBY, 34'h0f);
    rd(8'h24, {2'b10, 32'h0});
    wr(8'h24, 32'h1, 2'b10);
    clr_seen = 16'h0;
    wr(`SBX_OFS_ICLR, 32'hffff, 2'b00);
    repeat (2) @(posedge aclk);
    chk(clr_seen, 16'h2000);
    dma_active <= 1'b1;
    wr(`SBX_OFS_MSTPA, 32'hffff, 2'b00);
    rd(`SBX_OFS_MSTPA, 34'hdfff);
    dma_active <= 1'b0;
    wr(`SBX_OFS_MSTPA, 32'hffff, 2'b00);
    rd(`SBX_OFS_MSTPA, 34'hffff);
    seed = xs(seed);
    pdata = seed[7:0];
    wr(`SBX_OFS_PORTA, {16'h0, 8'hff, pdata}, 2'b00);
    wr(`SBX_OFS_SCK, 32'h0, 2'b00);
    look(16, seen);
    chk(seen, 2'b11);
    wr(`SBX_OFS_SCK, 32'h1, 2'b00);
    look(8, seen);
    look(16, seen);
    chk(seen, 2'b10);
    wr(`SBX_OFS_PORTA, {16'h0, 8'h7f, pdata}, 2'b00);
    repeat (2) @(posedge aclk);
    chk(port_a_oe, 8'h7f);
    wr(`SBX_OFS_PORTA, {16'h0, 8'hff, pdata}, 2'b00);
    wr(`SBX_OFS_SCK, 32'h0, 2'b00);
    for (i = 0; i < 13; i = i + 1)
      nap(i < 11 ? i[4:0] + 5'h05 : (i == 11 ? 5'h03 : 5'h10), i[0], i == 12);
    wr(`SBX_OFS_STBY, 32'h85, 2'b00);
    doze;
    seed = xs(seed);
    hold <= {10'h0, seed[5:0]};
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (rst_pulses == 0);
    repeat (2) @(posedge aclk);
    chk({rst_pulses[1:0], clock_supply, osc_enable}, 4'b0111);
    close_out;
  end
endmodule // sbx_top_bench
